// File: logic/audio_buf_pkg.sv
// constants shared by the audio sample buffer and its sample store
// assumes a 32-bit AXI4-Lite register bus with 12 address bits
`default_nettype none

package audio_buf_pkg;
    // bus geometry
    localparam int unsigned ADDR_W = 12;
    localparam int unsigned DATA_W = 32;
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // register indexes; byte address is four times the index
    localparam logic [7:0]        IDX_STATUS  = 8'h9c;
    localparam logic [7:0]        IDX_DATA    = 8'h9d;
    localparam logic [7:0]        IDX_CLKDIV  = 8'hec;
    localparam logic [ADDR_W-1:0] ADDR_STATUS = {2'h0, IDX_STATUS, 2'h0};
    localparam logic [ADDR_W-1:0] ADDR_DATA   = {2'h0, IDX_DATA, 2'h0};
    localparam logic [ADDR_W-1:0] ADDR_CLKDIV = {2'h0, IDX_CLKDIV, 2'h0};
    localparam logic [ADDR_W-1:0] ADDR_CTRL   = 12'h400;
    localparam logic [ADDR_W-1:0] ADDR_IRQ_ST = 12'h404;
    localparam logic [ADDR_W-1:0] ADDR_IRQ_CL = 12'h408;
    localparam logic [ADDR_W-1:0] ADDR_IRQ_EN = 12'h40c;

    // reset values
    localparam logic [7:0] STATUS_RST = 8'hc0;
    localparam logic [7:0] DATA_RST   = 8'hff;
    localparam logic [7:0] CLKDIV_RST = 8'h00;
    localparam logic [7:0] CTRL_RST   = 8'h00;

    // field positions
    localparam int unsigned ST_REQ_BIT   = 7;
    localparam int unsigned ST_UDR_BIT   = 6;
    localparam int unsigned ST_FULL_BIT  = 5;
    localparam int unsigned CT_EN_BIT    = 0;
    localparam int unsigned CT_DUP_LSB   = 1;
    localparam int unsigned CT_UMASK_BIT = 4;
    localparam int unsigned CT_RMASK_BIT = 5;
    localparam int unsigned CT_GEN_BIT   = 7;
    localparam int unsigned DIV_W        = 5;
    localparam int unsigned IRQ_W        = 3;
    localparam int unsigned IRQ_REQ      = 0;
    localparam int unsigned IRQ_UDR      = 1;
    localparam int unsigned IRQ_FULL     = 2;

    // buffer geometry and occupancy thresholds
    localparam int unsigned BUF_DEPTH  = 8;
    localparam int unsigned CNT_W      = 4;
    localparam logic [3:0]  HALF_LEVEL = 4'h4;
    localparam logic [3:0]  LAST_LEVEL = 4'h1;
    localparam logic [3:0]  NEAR_FULL  = 4'h7;
    localparam logic [7:0]  LOW_FILL   = 8'h00;

    // register select codes
    typedef enum logic [2:0] {
        SEL_NONE, SEL_STATUS, SEL_DATA, SEL_CLKDIV, SEL_CTRL, SEL_IRQ_ST, SEL_IRQ_CL, SEL_IRQ_EN
    } sel_t;

    // extra repeats of a sample for each duplication code
    function automatic logic [2:0] dup_repeats(input logic [1:0] code);
        case (code)
            2'h0:    dup_repeats = 3'h0;
            2'h1:    dup_repeats = 3'h1;
            2'h2:    dup_repeats = 3'h3;
            default: dup_repeats = 3'h5;
        endcase
    endfunction : dup_repeats
endpackage : audio_buf_pkg

`default_nettype wire

// File: logic/sample_fifo_if.sv
// signals between the buffer control and its sample store
// assumes the owner never pushes when full nor pops when empty
`timescale 1ns/1ns
`default_nettype none

interface sample_fifo_if #(
    parameter int unsigned WIDTH = 8,
    parameter int unsigned CW    = 4
);
    logic             push;
    logic [WIDTH-1:0] push_data;
    logic             pop;
    logic [WIDTH-1:0] head;
    logic [CW-1:0]    count;
    logic             full;
    logic             empty;

    modport owner (output push, push_data, pop, input head, count, full, empty);
    modport store (input push, push_data, pop, output head, count, full, empty);
endinterface : sample_fifo_if

`default_nettype wire

// File: logic/sample_fifo.sv
// circular sample store with occupancy count
// assumes one clock and guarded push and pop from the owner
`timescale 1ns/1ns
`default_nettype none

module sample_fifo #(
    parameter int unsigned WIDTH = 8,
    parameter int unsigned DEPTH = 8,
    parameter int unsigned CW    = 4
) (
    input wire logic      core_clk,
    input wire logic      rst_n,
    sample_fifo_if.store  fifo
);
    localparam int unsigned PW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0]    wr_ptr_q;
    logic [PW-1:0]    rd_ptr_q;
    logic [CW-1:0]    count_q;
    wire              do_push = fifo.push & ~fifo.full;
    wire              do_pop  = fifo.pop & ~fifo.empty;

    // wrap a pointer at the depth
    function automatic logic [PW-1:0] next_ptr(input logic [PW-1:0] p);
        next_ptr = (p == PW'(DEPTH - 1)) ? '0 : PW'(p + 1'b1);
    endfunction : next_ptr

    assign fifo.head  = mem[rd_ptr_q];
    assign fifo.count = count_q;
    assign fifo.full  = (count_q == CW'(DEPTH));
    assign fifo.empty = (count_q == '0);

    // storage array, no reset needed
    always_ff @(posedge core_clk) begin
        if (do_push) begin
            mem[wr_ptr_q] <= fifo.push_data;
        end
    end

    // pointers and occupancy
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            count_q  <= '0;
        end else begin
            if (do_push) wr_ptr_q <= next_ptr(wr_ptr_q);
            if (do_pop) rd_ptr_q <= next_ptr(rd_ptr_q);
            if (do_push & ~do_pop) count_q <= CW'(count_q + 1'b1);
            else if (do_pop & ~do_push) count_q <= CW'(count_q - 1'b1);
        end
    end
endmodule : sample_fifo

`default_nettype wire

// File: logic/audio_sample_buffer.sv
// audio sample buffer: processor-facing sample queue, flags, interrupts and audio clock divider
// assumes an AXI4-Lite master, a converter that takes samples by pcm_valid/pcm_ready,
// and an isr_enter pulse from the interrupt controller on service entry
//
// What this block does
// - sample-request flag sets at half empty, clears when a sample is accepted
// - under-run flag sets when buffer drains empty, clears when a sample is accepted
// - audio interrupt only when source unmasked and global enable set
// - buffer-full flag reads high exactly while the interface is enabled and the buffer is full
// - status register is read-only, bits 4 to 0 read zero
// - status resets with request and under-run flags set, rest clear
// - data register takes one 8-bit sample per write, resets to all ones
// - divider holds 5-bit value, upper bits read zero, resets to zero
// - eight-byte buffer; request sets on four to three, clears on any accepted sample
// - each sample widened to 16 bits with a zero low byte
// - duplication code repeats each sample 1, 2, 4 or 6 times
// - global pending cleared on service entry; source flags only by data writes
`timescale 1ns/1ns
`default_nettype none

module audio_sample_buffer #(
    parameter int unsigned DEPTH = 8
) (
    input  wire logic                              core_clk,
    input  wire logic                              rst_n,
    input  wire logic [audio_buf_pkg::ADDR_W-1:0]  s_axi_awaddr,
    input  wire logic                              s_axi_awvalid,
    output var  logic                              s_axi_awready,
    input  wire logic [audio_buf_pkg::DATA_W-1:0]  s_axi_wdata,
    input  wire logic [3:0]                        s_axi_wstrb,
    input  wire logic                              s_axi_wvalid,
    output var  logic                              s_axi_wready,
    output var  logic [1:0]                        s_axi_bresp,
    output var  logic                              s_axi_bvalid,
    input  wire logic                              s_axi_bready,
    input  wire logic [audio_buf_pkg::ADDR_W-1:0]  s_axi_araddr,
    input  wire logic                              s_axi_arvalid,
    output var  logic                              s_axi_arready,
    output var  logic [audio_buf_pkg::DATA_W-1:0]  s_axi_rdata,
    output var  logic [1:0]                        s_axi_rresp,
    output var  logic                              s_axi_rvalid,
    input  wire logic                              s_axi_rready,
    input  wire logic                              isr_enter,
    input  wire logic                              pcm_ready,
    output var  logic                              pcm_valid,
    output var  logic [15:0]                       pcm_data,
    output var  logic                              audio_clk_tick,
    output var  logic                              audio_irq,
    output var  logic                              irq
);
    import audio_buf_pkg::*;

    // decode a byte address to a register select
    function automatic sel_t decode_sel(input logic [ADDR_W-1:0] a);
        logic [ADDR_W-3:0] w;
        w = a[ADDR_W-1:2];
        if (w == ADDR_STATUS[ADDR_W-1:2])      decode_sel = SEL_STATUS;
        else if (w == ADDR_DATA[ADDR_W-1:2])   decode_sel = SEL_DATA;
        else if (w == ADDR_CLKDIV[ADDR_W-1:2]) decode_sel = SEL_CLKDIV;
        else if (w == ADDR_CTRL[ADDR_W-1:2])   decode_sel = SEL_CTRL;
        else if (w == ADDR_IRQ_ST[ADDR_W-1:2]) decode_sel = SEL_IRQ_ST;
        else if (w == ADDR_IRQ_CL[ADDR_W-1:2]) decode_sel = SEL_IRQ_CL;
        else if (w == ADDR_IRQ_EN[ADDR_W-1:2]) decode_sel = SEL_IRQ_EN;
        else                                   decode_sel = SEL_NONE;
    endfunction : decode_sel

    // bus channel state
    logic                  awready_q;
    logic                  wready_q;
    logic                  bvalid_q;
    logic [1:0]            bresp_q;
    logic                  arready_q;
    logic                  rvalid_q;
    logic [1:0]            rresp_q;
    logic [DATA_W-1:0]     rdata_q;
    logic                  aw_have_q;
    logic                  w_have_q;
    logic [ADDR_W-1:0]     aw_addr_q;
    logic [DATA_W-1:0]     w_data_q;
    logic [3:0]            w_strb_q;

    // block registers
    logic [7:0]            sample_byte_q;
    logic [DIV_W-1:0]      clock_divide_value_q;
    logic [7:0]            ctrl_q;
    logic                  sample_request_flag_q;
    logic                  underrun_flag_q;
    logic                  pending_q;
    logic [IRQ_W-1:0]      irq_stat_q;
    logic [IRQ_W-1:0]      irq_en_q;
    logic                  irq_q;
    logic [DIV_W-1:0]      div_cnt_q;
    logic                  tick_q;
    logic                  pcm_valid_q;
    logic [15:0]           pcm_data_q;
    logic [2:0]            rep_q;

    sample_fifo_if #(.WIDTH(8), .CW(CNT_W)) fifo_bus ();

    sample_fifo #(
        .WIDTH (8),
        .DEPTH (DEPTH),
        .CW    (CNT_W)
    ) u_store (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .fifo     (fifo_bus.owner)
    );

    // write channel handshakes and the write strobe
    wire  aw_take  = s_axi_awvalid & awready_q;
    wire  w_take   = s_axi_wvalid & wready_q;
    wire  wr_fire  = aw_have_q & w_have_q & ~bvalid_q;
    wire  aw_have_d = aw_have_q ? ~wr_fire : aw_take;
    wire  w_have_d  = w_have_q ? ~wr_fire : w_take;
    wire  bvalid_d  = wr_fire | (bvalid_q & ~s_axi_bready);
    wire  sel_t wsel = decode_sel(aw_addr_q);
    wire  lane0    = w_strb_q[0];

    // read channel handshake and select
    wire  ar_take  = s_axi_arvalid & arready_q;
    wire  rvalid_d = ar_take | (rvalid_q & ~s_axi_rready);
    wire  sel_t rsel = decode_sel(s_axi_araddr);

    // control fields
    wire        audio_interface_enable  = ctrl_q[CT_EN_BIT];
    wire [1:0]  duplication_factor      = ctrl_q[CT_DUP_LSB +: 2];
    wire        underrun_irq_mask       = ctrl_q[CT_UMASK_BIT];
    wire        request_irq_mask        = ctrl_q[CT_RMASK_BIT];
    wire        global_audio_irq_enable = ctrl_q[CT_GEN_BIT];

    // sample write: dropped when the buffer is full
    wire  data_wr  = wr_fire & (wsel == SEL_DATA) & lane0;
    wire  push     = data_wr & ~fifo_bus.full;
    wire  div_wr   = wr_fire & (wsel == SEL_CLKDIV) & lane0;
    wire  ctrl_wr  = wr_fire & (wsel == SEL_CTRL) & lane0;
    wire  ien_wr   = wr_fire & (wsel == SEL_IRQ_EN) & lane0;
    wire  icl_wr   = wr_fire & (wsel == SEL_IRQ_CL) & lane0;

    // output stage: repeat the held sample, else pull the next one
    wire  out_take = pcm_valid_q & pcm_ready;
    wire  need_load = ~pcm_valid_q | out_take;
    wire  repeat_held = pcm_valid_q & (rep_q != 3'h0);
    wire  pop = need_load & ~repeat_held & audio_interface_enable & ~fifo_bus.empty;

    // occupancy events, only from an actual change of count
    wire  cnt_down = pop & ~push;
    wire  cnt_up   = push & ~pop;
    wire  req_set  = audio_interface_enable & cnt_down & (fifo_bus.count == HALF_LEVEL);
    wire  udr_set  = audio_interface_enable & cnt_down & (fifo_bus.count == LAST_LEVEL);
    wire  full_set = cnt_up & (fifo_bus.count == NEAR_FULL);
    wire  buffer_full_flag = audio_interface_enable & fifo_bus.full;

    // flags: set wins over the clearing sample write
    wire  req_d = req_set | (sample_request_flag_q & ~push);
    wire  udr_d = udr_set | (underrun_flag_q & ~push);

    // global audio request from unmasked sources
    wire  src_set   = (req_set & ~request_irq_mask) | (udr_set & ~underrun_irq_mask);
    wire  pending_d = (global_audio_irq_enable & src_set) | (pending_q & ~isr_enter);

    // sticky event status, set wins over the clear register
    wire [IRQ_W-1:0] irq_evt = {full_set, udr_set, req_set};
    wire [IRQ_W-1:0] irq_clr = icl_wr ? w_data_q[IRQ_W-1:0] : '0;
    wire [IRQ_W-1:0] irq_stat_d = irq_evt | (irq_stat_q & ~irq_clr);
    wire             irq_any    = |(irq_stat_d & irq_en_q);

    // status byte with zero reserved bits
    wire [7:0] status_byte = {sample_request_flag_q, underrun_flag_q, buffer_full_flag, 5'h00};

    // read data mux; write-only registers read as zero
    wire [DATA_W-1:0] rd_mux =
        (rsel == SEL_STATUS) ? {24'h00_0000, status_byte} :
        (rsel == SEL_CLKDIV) ? {27'h000_0000, clock_divide_value_q} :
        (rsel == SEL_CTRL)   ? {24'h00_0000, ctrl_q} :
        (rsel == SEL_IRQ_ST) ? {29'h0000_0000, irq_stat_q} :
        (rsel == SEL_IRQ_EN) ? {29'h0000_0000, irq_en_q} :
        32'h0000_0000;

    // writes to the status register, the interrupt status register or unmapped space answer with an error
    wire  wr_bad = (wsel == SEL_NONE) | (wsel == SEL_STATUS) | (wsel == SEL_IRQ_ST);
    wire  rd_bad = (rsel == SEL_NONE);

    // divider tick when the count reaches the programmed value
    wire  div_hit = (div_cnt_q == clock_divide_value_q);

    assign fifo_bus.push      = push;
    assign fifo_bus.push_data = s_axi_wdata_byte(w_data_q);
    assign fifo_bus.pop       = pop;

    // low byte of the held write data
    function automatic logic [7:0] s_axi_wdata_byte(input logic [DATA_W-1:0] d);
        s_axi_wdata_byte = d[7:0];
    endfunction : s_axi_wdata_byte

    // write address capture
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            aw_have_q <= 1'b0;
            aw_addr_q <= '0;
        end else begin
            aw_have_q <= aw_have_d;
            if (aw_take) aw_addr_q <= s_axi_awaddr;
        end
    end

    // write data and strobe capture
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            w_have_q  <= 1'b0;
            w_data_q  <= '0;
            w_strb_q  <= 4'h0;
        end else begin
            w_have_q  <= w_have_d;
            if (w_take) begin
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
            end
        end
    end

    // write readies and response valid
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            awready_q <= 1'b0;
            wready_q  <= 1'b0;
            bvalid_q  <= 1'b0;
        end else begin
            awready_q <= ~aw_have_d & ~bvalid_d;
            wready_q  <= ~w_have_d & ~bvalid_d;
            bvalid_q  <= bvalid_d;
        end
    end

    // write response code, fixed when the write is applied
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            bresp_q <= RESP_OKAY;
        end else if (wr_fire) begin
            bresp_q <= wr_bad ? RESP_SLVERR : RESP_OKAY;
        end
    end

    // read ready and valid
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            arready_q <= 1'b0;
            rvalid_q  <= 1'b0;
        end else begin
            arready_q <= ~rvalid_d;
            rvalid_q  <= rvalid_d;
        end
    end

    // read data and response, captured at the address handshake
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rresp_q <= RESP_OKAY;
            rdata_q <= '0;
        end else if (ar_take) begin
            rdata_q <= rd_mux;
            rresp_q <= rd_bad ? RESP_SLVERR : RESP_OKAY;
        end
    end

    // software registers
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            sample_byte_q        <= DATA_RST;
            clock_divide_value_q <= CLKDIV_RST[DIV_W-1:0];
            ctrl_q               <= CTRL_RST;
            irq_en_q             <= '0;
        end else begin
            if (push) sample_byte_q <= w_data_q[7:0];
            if (div_wr) clock_divide_value_q <= w_data_q[DIV_W-1:0];
            if (ctrl_wr) ctrl_q <= w_data_q[7:0] & 8'hb7;
            if (ien_wr) irq_en_q <= w_data_q[IRQ_W-1:0];
        end
    end

    // status flags and global pending
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            sample_request_flag_q <= STATUS_RST[ST_REQ_BIT];
            underrun_flag_q       <= STATUS_RST[ST_UDR_BIT];
            pending_q             <= 1'b0;
        end else begin
            sample_request_flag_q <= req_d;
            underrun_flag_q       <= udr_d;
            pending_q             <= pending_d;
        end
    end

    // sticky event status and its level interrupt
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_stat_q <= '0;
            irq_q      <= 1'b0;
        end else begin
            irq_stat_q <= irq_stat_d;
            irq_q      <= irq_any;
        end
    end

    // widened and duplicated sample toward the converter
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            pcm_valid_q <= 1'b0;
            pcm_data_q  <= 16'h0000;
            rep_q       <= 3'h0;
        end else if (need_load) begin
            if (repeat_held) begin
                rep_q <= 3'(rep_q - 1'b1);
            end else if (pop) begin
                pcm_valid_q <= 1'b1;
                pcm_data_q  <= {fifo_bus.head, LOW_FILL};
                rep_q       <= dup_repeats(duplication_factor);
            end else begin
                pcm_valid_q <= 1'b0;
            end
        end
    end

    // audio clock divider
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            div_cnt_q <= '0;
            tick_q    <= 1'b0;
        end else begin
            div_cnt_q <= (div_wr | div_hit) ? '0 : DIV_W'(div_cnt_q + 1'b1);
            tick_q    <= div_hit & ~div_wr;
        end
    end

    // outputs straight from flip-flops
    assign s_axi_awready  = awready_q;
    assign s_axi_wready   = wready_q;
    assign s_axi_bvalid   = bvalid_q;
    assign s_axi_bresp    = bresp_q;
    assign s_axi_arready  = arready_q;
    assign s_axi_rvalid   = rvalid_q;
    assign s_axi_rresp    = rresp_q;
    assign s_axi_rdata    = rdata_q;
    assign pcm_valid      = pcm_valid_q;
    assign pcm_data       = pcm_data_q;
    assign audio_clk_tick = tick_q;
    assign audio_irq      = pending_q;
    assign irq            = irq_q;
endmodule : audio_sample_buffer

`default_nettype wire

// File: test/pcm_sink_model.sv
// sample sink standing for the output converter
// assumes one clock; stall holds ready low so the buffer backs up
`timescale 1ns/1ns
`default_nettype none
module pcm_sink_model (
    input  wire logic        core_clk,
    input  wire logic        rst_n,
    input  wire logic        pcm_valid,
    input  wire logic [15:0] pcm_data,
    input  wire logic        stall,
    output var  logic        pcm_ready,
    output var  logic [7:0]  last_byte,
    output var  int unsigned taken
);
    // ready only while not stalled
    assign pcm_ready = !stall;
    // count taken samples, keep the high byte
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            taken     <= 0;
            last_byte <= 8'h00;
        end else if (pcm_valid && pcm_ready) begin
            taken     <= taken + 1;
            last_byte <= pcm_data[15:8];
        end
    end
endmodule : pcm_sink_model
`default_nettype wire

// File: test/audio_sample_buffer_checker.sv
// bus answer, sample stream and pending flag timing
// assumes binding onto audio_sample_buffer
`timescale 1ns/1ns
`default_nettype none
module audio_sample_buffer_checker (
    input wire logic        core_clk,
    input wire logic        rst_n,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        isr_enter,
    input wire logic        pcm_ready,
    input wire logic        pcm_valid,
    input wire logic [15:0] pcm_data,
    input wire logic        audio_irq
);
    // one domain
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
        else $error("write answer late");
    a_write_refuse: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready [*2])
        else $error("address taken twice");
    a_resp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write answer dropped");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
        else $error("read answer late");
    a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data moved");
    a_low_fill: assert property (pcm_valid |-> pcm_data[7:0] == 8'h00)
        else $error("low byte not zero");
    a_sample_hold: assert property (pcm_valid && !pcm_ready |=> pcm_valid && $stable(pcm_data))
        else $error("sample moved while stalled");
    a_pending_clear: assert property ($fell(audio_irq) |-> $past(isr_enter))
        else $error("pending cleared without service entry");
endmodule : audio_sample_buffer_checker
bind audio_sample_buffer audio_sample_buffer_checker i_audio_sample_buffer_checker (.*);
`default_nettype wire

// File: test/tb.sv
// registers, fill and drain, interrupts, duplication and clock tick
// assumes the sink model and the bound checker
`timescale 1ns/1ns
`default_nettype none
module tb;
    import audio_buf_pkg::*;
    logic        core_clk, rst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
    logic        isr_enter, stall, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic        pcm_ready, pcm_valid, audio_clk_tick, audio_irq, irq;
    logic [11:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, q;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp, r;
    logic [15:0] pcm_data;
    logic [7:0]  last_byte;
    int unsigned taken, base, reps;
    int          error_cnt, total_checks, n;
    logic [11:0] ra [6] = '{ADDR_STATUS, ADDR_DATA, ADDR_CLKDIV, ADDR_CTRL, ADDR_IRQ_ST, 12'h010};
    logic [31:0] rq [6] = '{{24'h00_0000, STATUS_RST}, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0};
    logic [1:0]  rr [6] = '{RESP_OKAY, RESP_OKAY, RESP_OKAY, RESP_OKAY, RESP_OKAY, RESP_SLVERR};
    audio_sample_buffer i_audio_sample_buffer (.*);
    pcm_sink_model i_pcm_sink_model (.*);
    // clock
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    task automatic finish_test;
        $display("checks %0d mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : finish_test
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic guard;
        n++;
        if (n > 300) begin
            error_cnt++;
            finish_test();
        end
    endtask : guard
    // one register transfer, answer caught on the falling edge before the handshake
    task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
        logic ta, tw, tr, done;
        done = 1'b0;
        n = 0;
        @(posedge core_clk);
        if (w)
            {s_axi_awaddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {a, d, 3'b111};
        else
            {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'b11};
        while (!done) begin
            @(negedge core_clk);
            {ta, tw, tr} = {s_axi_awready, s_axi_wready, s_axi_arready};
            done = w ? s_axi_bvalid : s_axi_rvalid;
            {q, r} = {s_axi_rdata, w ? s_axi_bresp : s_axi_rresp};
            @(posedge core_clk);
            if (ta) s_axi_awvalid <= 1'b0;
            if (tw) s_axi_wvalid <= 1'b0;
            if (tr) s_axi_arvalid <= 1'b0;
            if (done) {s_axi_bready, s_axi_rready} <= 2'b00;
            guard();
        end
    endtask : bus
    // main sequence
    initial begin
        {rst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, isr_enter} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, error_cnt, total_checks} = '0;
        {s_axi_wstrb, stall} = 5'h1f;
        repeat (4) @(posedge core_clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 6; i++) begin
            bus(0, ra[i], 32'h0);
            chk(q, rq[i]);
            chk(r, rr[i]);
        end
        bus(1, ADDR_CLKDIV, 32'hffff_ffff);
        bus(0, ADDR_CLKDIV, 32'h0);
        chk(q, 32'h0000_001f);
        bus(1, ADDR_STATUS, 32'h0000_00ff);
        chk(r, RESP_SLVERR);
        $display("register table done");
        bus(1, ADDR_CTRL, 32'h0000_0081);
        for (int i = 1; i <= 10; i++) bus(1, ADDR_DATA, i); // output stage holds one, buffer eight
        chk(r, RESP_OKAY);
        bus(0, ADDR_STATUS, 32'h0);
        chk(q, 32'h0000_0020);
        bus(1, ADDR_IRQ_EN, 32'h0000_0004);
        #1 chk(irq, 1'b1);
        bus(1, ADDR_IRQ_CL, 32'h0000_0004);
        #1 chk(irq, 1'b0);
        stall <= 1'b0;
        while (taken < 9) begin
            @(negedge core_clk);
            guard();
        end
        repeat (20) @(posedge core_clk);
        chk(taken, 9);
        chk(last_byte, 8'h09);
        bus(0, ADDR_STATUS, 32'h0);
        chk(q, {24'h00_0000, STATUS_RST});
        #1 chk(audio_irq, 1'b1);
        bus(0, ADDR_IRQ_ST, 32'h0);
        chk(q, 32'h0000_0003);
        #1 chk(irq, 1'b0);
        bus(1, ADDR_IRQ_EN, 32'h0000_0007);
        #1 chk(irq, 1'b1);
        isr_enter <= 1'b1;
        @(posedge core_clk);
        isr_enter <= 1'b0;
        #1 chk(audio_irq, 1'b0);
        bus(0, ADDR_IRQ_ST, 32'h0);
        chk(q, 32'h0000_0003);
        $display("fill and drain done");
        for (int c = 0; c < 4; c++) begin
            reps = (c == 3) ? 6 : (1 << c);
            base = taken;
            bus(1, ADDR_CTRL, 32'h0000_00b1 | (c << 1));
            bus(1, ADDR_DATA, 32'h0000_00a0 + c);
            while (taken < base + reps) begin
                @(negedge core_clk);
                guard();
            end
            repeat (16) @(posedge core_clk);
            chk(taken, base + reps);
            chk(last_byte, 8'ha0 + c);
            #1 chk(audio_irq, 1'b0);
        end
        $display("duplication done");
        bus(1, ADDR_CLKDIV, 32'h0000_0003);
        while (audio_clk_tick !== 1'b1) begin
            @(negedge core_clk);
            guard();
        end
        n = 0;
        do begin
            @(negedge core_clk);
            guard();
        end while (audio_clk_tick !== 1'b1);
        chk(n, 4);
        $display("clock tick done");
        finish_test();
    end
endmodule : tb
`default_nettype wire
